// ===== shared/gei_pkg.sv
// Constants shared by the gauge event indicator and its pulse timer.
// Assumes a single 40 MHz clock domain.
package gei_pkg;
    // ==========================================
    // Clock and times
    localparam int CLK_PERIOD_NS = 25;
    localparam int PULSE_WIDTH_NS = 1000000;
    localparam int PULSE_CYC = (PULSE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FLASH_UNIT_NS = 5000;
    localparam int FLASH_UNIT_CYC = (FLASH_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SECOND_NS = 1000000000;
    localparam int SECOND_CYC = SECOND_NS / CLK_PERIOD_NS;
    // ==========================================
    // Operating states and pin function codes
    localparam logic [1:0] OP_RELAX = 2'h0;
    localparam logic [1:0] OP_CHG = 2'h1;
    localparam logic [1:0] OP_DSG = 2'h2;
    localparam logic [1:0] PFC_0 = 2'h0;
    localparam logic [1:0] PFC_1 = 2'h1;
    localparam logic [1:0] PFC_2 = 2'h2;
    // ==========================================
    // Levels and reset values
    localparam logic [7:0] SOC_FULL = 8'h64;
    localparam logic [7:0] SOC_EMPTY = 8'h00;
    localparam logic [1:0] TERM_WINDOWS = 2'h2;
    localparam logic [15:0] TERM_DCAP_UAH = 16'h00fa;
    localparam logic [15:0] TEMP_RST = 16'h0000;
    typedef enum logic [1:0] {FL_IDLE, FL_WAIT, FL_WRITE} gei_flash_t;
endpackage

// ===== shared/gei_pulse_if.sv
// Request and answer between the event logic and the pulse timer.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
interface gei_pulse_if;
    logic fire;
    logic hold;
    logic active;
    modport src (output fire, output hold, input active);
    modport gen (input fire, input hold, output active);
endinterface

// ===== logic/gei_pulse_gen.sv
// Fixed-width pulse timer with level hold, merging retriggers.
// Assumes fire and hold come from logic on the same clock.
`timescale 1ns/100ps
module gei_pulse_gen #(
    parameter int CYC = gei_pkg::PULSE_CYC
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // Pulse requests
    gei_pulse_if.gen pif
);
    localparam int CW = $clog2(CYC + 1);
    logic [CW-1:0] cnt_r;
    logic active_r;

    // ==========================================
    // Width counter
    // A retrigger reloads the count, so overlapping pulses merge and always end.
    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
            cnt_r <= '0;
        else if (pif.fire)
            cnt_r <= CW'(CYC); // [RL26] [RL27]
        else if (cnt_r != '0)
            cnt_r <= cnt_r - 1'b1;
    end

    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
            active_r <= 1'b0;
        else
            active_r <= pif.fire || (cnt_r > CW'(1)) || pif.hold; // [RL1]
    end

    assign pif.active = active_r;

    // ==========================================
    // Checks
    AST_PULSE_START: assert property (@(posedge ref_clk) disable iff (!nrst) // [RL26]
        pif.fire |=> active_r) else $error("Pulse did not start after fire.");
    AST_PULSE_END: assert property (@(posedge ref_clk) disable iff (!nrst) // [RL27]
        (cnt_r == '0 && !pif.fire && !pif.hold) |=> !active_r)
        else $error("Pulse stuck without cause.");
    COV_HOLD: cover property (@(posedge ref_clk) disable iff (!nrst) pif.hold ##1 active_r);
endmodule // gei_pulse_gen

// ===== logic/gei_top.sv
// Event indication, temperature source, overtemperature, termination, charge inhibit.
// Assumes all inputs come from gauge logic on ref_clk; one-cycle event strobes.
`timescale 1ns/100ps
// What this block does
// [RL1] Interrupt output pulses with a width chosen by the triggering event.
// [RL2] Charging: 1 ms pulse at each step point and at 100%, step nonzero.
// [RL3] Discharging: 1 ms pulse below each step point and at 0%, step nonzero.
// [RL4] 1 ms pulse when charge percent reaches low level set or clear threshold.
// [RL5] 1 ms pulse when voltage reaches shutdown set or clear threshold.
// [RL6] 1 ms pulse on operating state change when step nonzero.
// [RL7] 1 ms pulse on battery removal when removal pulse is enabled.
// [RL8] After init, interrupt held for the whole open-circuit-voltage command.
// [RL9] Interrupt held during init voltage measurement when enabled.
// [RL10] After init, before a flash update, interrupt held through a wait of delay times 5 us and the write.
// [RL11] Delay count zero means no flash update indication.
// [RL12] Interrupt held during factory restore of learned tables.
// [RL13] External thermistor used unless sensor select bit is cleared.
// [RL14] Temperature returned to the host whatever source is selected.
// [RL15] Charge overheat flag set after timed overheat with current, cleared at recovery.
// [RL16] Charge overheat time zero disables that detection.
// [RL17] Discharge overheat flag set after timed overheat, cleared at charge recovery.
// [RL18] Discharge overheat time zero disables that detection.
// [RL19] Charging flag cleared after two taper windows meet termination.
// [RL20] On termination, load remaining capacity from full capacity if enabled.
// [RL21] Pin code 1: battery-good inhibits outside window, recovers inside hysteresis.
// [RL22] Pin code 0 or 2: sample on host query, no periodic update charging.
// [RL23] Pin code bits 00, 01, 10 select codes 0, 1, 2.
// [RL24] Interrupt output active low while its polarity bit is cleared.
// [RL25] Battery-good line active low while its polarity bit is cleared.
// [RL26] Each fixed pulse timed by a counter on the own clock.
// [RL27] Concurrent triggers merge into one pulse that always ends.
module gei_top #(
    parameter int PULSE_CYCLES = gei_pkg::PULSE_CYC,
    parameter int SECOND_CYCLES = gei_pkg::SECOND_CYC
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // Configuration
    input wire logic external_sensor_select,
    input wire logic charge_irq_polarity,
    input wire logic battery_good_polarity,
    input wire logic pin_function_bit_hi,
    input wire logic pin_function_bit_lo,
    input wire logic removal_pulse_enable,
    input wire logic init_ocv_pulse_enable,
    input wire logic remaining_to_full_on_term,
    input wire logic [7:0] soc_step,
    input wire logic [15:0] flash_write_notice_delay,
    input wire logic [7:0] low_charge_set,
    input wire logic [7:0] low_charge_clear,
    input wire logic [15:0] shutdown_set_mv,
    input wire logic [15:0] shutdown_clear_mv,
    // Temperature limits, 0.1 K units, times in seconds
    input wire logic [15:0] ot_chg,
    input wire logic [7:0] ot_chg_time,
    input wire logic [15:0] ot_chg_recovery,
    input wire logic [15:0] ot_dsg,
    input wire logic [7:0] ot_dsg_time,
    input wire logic [15:0] inhibit_low,
    input wire logic [15:0] inhibit_high,
    input wire logic [15:0] temp_hys,
    // Currents in mA, signed, and termination settings
    input wire logic signed [15:0] avg_current,
    input wire logic signed [15:0] chg_current_thr,
    input wire logic signed [15:0] dsg_current_thr,
    input wire logic signed [15:0] taper_current,
    input wire logic [15:0] charging_voltage,
    input wire logic [15:0] taper_voltage,
    input wire logic [15:0] cap_delta_uah,
    input wire logic taper_window_end,
    // Gauge measurements and events
    input wire logic [7:0] relative_charge_pct,
    input wire logic [15:0] voltage_mv,
    input wire logic [15:0] thermistor_input,
    input wire logic [15:0] internal_temp,
    input wire logic [1:0] op_state,
    input wire logic temp_tick,
    input wire logic temp_query,
    input wire logic battery_removed,
    input wire logic init_done,
    input wire logic ocv_busy,
    input wire logic flash_update_req,
    input wire logic flash_busy,
    input wire logic restore_busy,
    // Outputs
    output logic charge_irq,
    output logic battery_good_n,
    output logic [15:0] battery_temp,
    output logic temp_ready,
    output logic charge_overheat_flag,
    output logic discharge_overheat_flag,
    output logic charging_flag,
    output logic rm_load_fcc,
    output logic flash_erase_start
);
    function automatic logic [1:0] pfc_decode(input logic hi, input logic lo);
        pfc_decode = (hi && !lo) ? gei_pkg::PFC_2 : (!hi && !lo) ? gei_pkg::PFC_0
                                                              : gei_pkg::PFC_1;
    endfunction

    gei_pulse_if pif ();
    gei_pulse_gen #(.CYC(PULSE_CYCLES)) u_pulse (.ref_clk(ref_clk), .nrst(nrst), .pif(pif));

    logic [1:0] pin_function_code;
    logic step_on, chg, dsg;
    logic [7:0] step_ref_r, soc_prev_r;
    logic step_sync_r, step_up, step_dn;
    logic soc_lo_r, soc_hi_r, v_lo_r, v_hi_r, hist_ok_r;
    logic [1:0] op_prev_r;
    gei_pkg::gei_flash_t fl_r;
    logic [23:0] fl_cnt_r;
    logic [25:0] sec_cnt_r;
    logic sec_tick;
    logic [7:0] otc_cnt_r, otd_cnt_r;
    logic [1:0] term_cnt_r;
    logic term_ok, term_hit;
    logic [15:0] temp_sel;
    logic inhibit_r;
    logic [8:0] step_top;

    assign pin_function_code = pfc_decode(pin_function_bit_hi, pin_function_bit_lo); // [RL23]
    assign step_on = (soc_step != 8'h00);
    assign chg = (op_state == gei_pkg::OP_CHG);
    assign dsg = (op_state == gei_pkg::OP_DSG);
    assign temp_sel = external_sensor_select ? thermistor_input : internal_temp; // [RL13]

    // ==========================================
    // Step points, referenced down from full
    assign step_top = {1'b0, step_ref_r} + {1'b0, soc_step};
    assign step_up = (step_ref_r != gei_pkg::SOC_FULL)
                     && ({1'b0, relative_charge_pct} >= step_top);
    assign step_dn = (relative_charge_pct < step_ref_r) && (step_ref_r >= soc_step);

    always_ff @(posedge ref_clk)
    begin
        if (!nrst || !step_on)
            step_ref_r <= gei_pkg::SOC_FULL;
        else if (step_up)
            step_ref_r <= step_top[7:0];
        else if (step_dn)
            step_ref_r <= step_ref_r - soc_step;
    end

    // The reference walks one point per cycle, so step pulses wait until it has first settled after reset or a zero step.
    always_ff @(posedge ref_clk)
    begin
        if (!nrst || !step_on)
            step_sync_r <= 1'b0;
        else if (!step_up && !step_dn)
            step_sync_r <= 1'b1;
    end

    // ==========================================
    // Level crossing history
    // History is trusted only from the second cycle, so no false edge follows reset.
    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
        begin
            soc_prev_r <= gei_pkg::SOC_FULL;
            soc_lo_r <= 1'b0;
            soc_hi_r <= 1'b0;
            v_lo_r <= 1'b0;
            v_hi_r <= 1'b0;
            op_prev_r <= gei_pkg::OP_RELAX;
            hist_ok_r <= 1'b0;
        end
        else
        begin
            soc_prev_r <= relative_charge_pct;
            soc_lo_r <= relative_charge_pct <= low_charge_set;
            soc_hi_r <= relative_charge_pct >= low_charge_clear;
            v_lo_r <= voltage_mv <= shutdown_set_mv;
            v_hi_r <= voltage_mv >= shutdown_clear_mv;
            op_prev_r <= op_state;
            hist_ok_r <= 1'b1;
        end
    end

    // ==========================================
    // Pulse triggers
    always_comb
    begin
        pif.fire = 1'b0;
        if (step_sync_r && step_up && chg)
            pif.fire = 1'b1; // [RL2]
        if (step_sync_r && step_dn && dsg)
            pif.fire = 1'b1; // [RL3]
        if (hist_ok_r && step_on && dsg && relative_charge_pct == gei_pkg::SOC_EMPTY
            && soc_prev_r != gei_pkg::SOC_EMPTY)
            pif.fire = 1'b1; // [RL3]
        if (hist_ok_r && ((relative_charge_pct <= low_charge_set && !soc_lo_r)
            || (relative_charge_pct >= low_charge_clear && !soc_hi_r)))
            pif.fire = 1'b1; // [RL4]
        if (hist_ok_r && ((voltage_mv <= shutdown_set_mv && !v_lo_r)
            || (voltage_mv >= shutdown_clear_mv && !v_hi_r)))
            pif.fire = 1'b1; // [RL5]
        if (hist_ok_r && step_on && op_state != op_prev_r)
            pif.fire = 1'b1; // [RL6]
        if (battery_removed && removal_pulse_enable)
            pif.fire = 1'b1; // [RL7]
    end

    assign pif.hold = (ocv_busy && init_done) // [RL8]
                      || (ocv_busy && !init_done && init_ocv_pulse_enable) // [RL9]
                      || (fl_r != gei_pkg::FL_IDLE) // [RL10]
                      || restore_busy; // [RL12]

    // ==========================================
    // Flash update notice
    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
        begin
            fl_r <= gei_pkg::FL_IDLE;
            fl_cnt_r <= 24'h000000;
            flash_erase_start <= 1'b0;
        end
        else
        begin
            flash_erase_start <= 1'b0;
            case (fl_r)
                gei_pkg::FL_IDLE:
                    if (flash_update_req && init_done && flash_write_notice_delay != 16'h0000)
                    begin
                        fl_r <= gei_pkg::FL_WAIT; // [RL10]
                        fl_cnt_r <= 24'(flash_write_notice_delay)
                                    * 24'(gei_pkg::FLASH_UNIT_CYC);
                    end
                    else if (flash_update_req)
                        flash_erase_start <= 1'b1; // [RL11]
                gei_pkg::FL_WAIT:
                    if (fl_cnt_r == 24'h000001)
                    begin
                        fl_r <= gei_pkg::FL_WRITE;
                        flash_erase_start <= 1'b1;
                    end
                    else
                        fl_cnt_r <= fl_cnt_r - 24'h000001;
                gei_pkg::FL_WRITE:
                    if (!flash_busy && !flash_erase_start)
                        fl_r <= gei_pkg::FL_IDLE;
                default:
                    fl_r <= gei_pkg::FL_IDLE;
            endcase
        end
    end

    // ==========================================
    // Temperature sampling
    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
        begin
            battery_temp <= gei_pkg::TEMP_RST;
            temp_ready <= 1'b0;
        end
        else
        begin
            temp_ready <= temp_query; // [RL14]
            if (temp_query || (temp_tick && (pin_function_code == gei_pkg::PFC_1 || !chg)))
                battery_temp <= temp_sel; // [RL22]
        end
    end

    // ==========================================
    // Overtemperature timing
    assign sec_tick = (sec_cnt_r == 26'(SECOND_CYCLES - 1));

    always_ff @(posedge ref_clk)
    begin
        if (!nrst || sec_tick)
            sec_cnt_r <= 26'h0000000;
        else
            sec_cnt_r <= sec_cnt_r + 26'h0000001;
    end

    always_ff @(posedge ref_clk)
    begin
        if (!nrst || !(chg && battery_temp >= ot_chg && avg_current > chg_current_thr))
            otc_cnt_r <= 8'h00;
        else if (sec_tick && otc_cnt_r != 8'hff)
            otc_cnt_r <= otc_cnt_r + 8'h01;
        if (!nrst || !(dsg && battery_temp >= ot_dsg && avg_current <= -dsg_current_thr))
            otd_cnt_r <= 8'h00;
        else if (sec_tick && otd_cnt_r != 8'hff)
            otd_cnt_r <= otd_cnt_r + 8'h01;
    end

    // A set in the same cycle as a recovery wins.
    always_ff @(posedge ref_clk)
    begin
        if (!nrst || ot_chg_time == 8'h00)
            charge_overheat_flag <= 1'b0; // [RL16]
        else if (otc_cnt_r >= ot_chg_time)
            charge_overheat_flag <= 1'b1; // [RL15]
        else if (battery_temp <= ot_chg_recovery)
            charge_overheat_flag <= 1'b0; // [RL15]
        if (!nrst || ot_dsg_time == 8'h00)
            discharge_overheat_flag <= 1'b0; // [RL18]
        else if (otd_cnt_r >= ot_dsg_time)
            discharge_overheat_flag <= 1'b1; // [RL17]
        else if (battery_temp <= ot_chg_recovery)
            discharge_overheat_flag <= 1'b0; // [RL17]
    end

    // ==========================================
    // Charge termination
    assign term_ok = (avg_current < taper_current) && (cap_delta_uah > gei_pkg::TERM_DCAP_UAH)
                     && ({1'b0, voltage_mv} > ({1'b0, charging_voltage} - {1'b0, taper_voltage}));
    assign term_hit = taper_window_end && term_ok && chg
                      && (term_cnt_r == gei_pkg::TERM_WINDOWS - 2'h1);

    always_ff @(posedge ref_clk)
    begin
        if (!nrst || !chg)
            term_cnt_r <= 2'h0;
        else if (taper_window_end)
            term_cnt_r <= (term_ok && !term_hit) ? term_cnt_r + 2'h1 : 2'h0; // [RL19]
    end

    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
        begin
            charging_flag <= 1'b0;
            rm_load_fcc <= 1'b0;
        end
        else
        begin
            rm_load_fcc <= term_hit && remaining_to_full_on_term; // [RL20]
            if (term_hit)
                charging_flag <= 1'b0; // [RL19]
            else if (chg && op_prev_r != gei_pkg::OP_CHG)
                charging_flag <= 1'b1;
            else if (!chg)
                charging_flag <= 1'b0;
        end
    end

    // ==========================================
    // Charge inhibit and pin levels
    always_ff @(posedge ref_clk)
    begin
        if (!nrst || pin_function_code != gei_pkg::PFC_1)
            inhibit_r <= 1'b0;
        else if (battery_temp < inhibit_low || battery_temp > inhibit_high)
            inhibit_r <= 1'b1; // [RL21]
        else if (battery_temp >= inhibit_low + temp_hys
                 && battery_temp <= inhibit_high - temp_hys)
            inhibit_r <= 1'b0; // [RL21]
    end

    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
        begin
            charge_irq <= 1'b1;
            battery_good_n <= 1'b0;
        end
        else
        begin
            charge_irq <= charge_irq_polarity ? pif.active : !pif.active; // [RL24]
            battery_good_n <= battery_good_polarity ? !inhibit_r : inhibit_r; // [RL25]
        end
    end

    // ==========================================
    // Checks
    AST_STATE_PULSE: assert property (@(posedge ref_clk) disable iff (!nrst) // [RL6]
        (hist_ok_r && step_on && op_state != op_prev_r)
        |-> ##2 (charge_irq == charge_irq_polarity))
        else $error("State change gave no interrupt.");
    AST_REMOVAL: assert property (@(posedge ref_clk) disable iff (!nrst) // [RL7]
        (battery_removed && removal_pulse_enable) |-> ##2 (charge_irq == charge_irq_polarity))
        else $error("Removal gave no interrupt.");
    AST_FLASH_QUIET: assert property (@(posedge ref_clk) disable iff (!nrst) // [RL11]
        (fl_r == gei_pkg::FL_IDLE && flash_update_req && flash_write_notice_delay == 16'h0000)
        |=> (fl_r == gei_pkg::FL_IDLE && flash_erase_start))
        else $error("Zero delay still gave a notice.");
    AST_FLASH_WAIT: assert property (@(posedge ref_clk) disable iff (!nrst) // [RL10]
        (fl_r == gei_pkg::FL_IDLE && flash_update_req && init_done
         && flash_write_notice_delay == 16'h0001)
        |-> ##200 !flash_erase_start ##1 flash_erase_start)
        else $error("Flash start not after the notice delay.");
    AST_OTC_OFF: assert property (@(posedge ref_clk) disable iff (!nrst) // [RL16]
        (ot_chg_time == 8'h00) |=> !charge_overheat_flag)
        else $error("Charge overheat set while disabled.");
    AST_OTD_OFF: assert property (@(posedge ref_clk) disable iff (!nrst) // [RL18]
        (ot_dsg_time == 8'h00) |=> !discharge_overheat_flag)
        else $error("Discharge overheat set while disabled.");
    AST_TERM: assert property (@(posedge ref_clk) disable iff (!nrst) // [RL20]
        term_hit |=> (!charging_flag && rm_load_fcc == $past(remaining_to_full_on_term)))
        else $error("Termination not applied.");
    AST_QUERY: assert property (@(posedge ref_clk) disable iff (!nrst) // [RL14]
        temp_query |=> (temp_ready && battery_temp == $past(temp_sel)))
        else $error("Query did not return temperature.");
    AST_NO_INHIBIT: assert property (@(posedge ref_clk) disable iff (!nrst) // [RL21]
        (pin_function_code != gei_pkg::PFC_1) |=> ##1 (battery_good_n == battery_good_polarity))
        else $error("Inhibit outside pin code 1.");
    COV_STEP: cover property (@(posedge ref_clk) disable iff (!nrst) step_sync_r && step_dn && dsg);
    COV_TERM: cover property (@(posedge ref_clk) disable iff (!nrst) term_hit);
    COV_FLASH: cover property (@(posedge ref_clk) disable iff (!nrst) fl_r == gei_pkg::FL_WRITE);
endmodule // gei_top

// ===== sim/gei_host_model.sv
// Host and charger model: asks for the temperature and watches the inhibit line.
// Assumes temp_ready follows a taken query by one cycle and inhibit is high at default polarity.
`timescale 1ns/100ps
// ==========================================
// Host and charger
module gei_host_model (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // Bench request and block answers
    input wire logic query_req,
    input wire logic temp_ready,
    input wire logic [15:0] battery_temp,
    input wire logic battery_good_n,
    // Query, last reading, charger state
    output logic temp_query = 1'b0,
    output logic [15:0] temp_seen = 16'h0000,
    output logic charger_off
);
    logic req_r = 1'b0;
    always @(posedge ref_clk)
    begin
        req_r <= query_req & nrst;
        if (temp_ready === 1'b1)
        begin
            temp_seen <= battery_temp;
        end
    end
    // Launched off the sampling edge, so the block never sees it move at its own edge.
    always @(negedge ref_clk)
    begin
        temp_query <= req_r;
    end
    assign charger_off = battery_good_n;
endmodule // gei_host_model

// ===== sim/gauge_event_indicator_bench.sv
// Bench for the gauge event indicator: reset, removal pulse, temperature, flash notice, inhibit.
// Assumes the host and charger model of gei_host_model.
`timescale 1ns/100ps
// ==========================================
// Bench top
module gauge_event_indicator_bench;
    localparam int P = 20;
    logic ref_clk = 1'b0, nrst = 1'b0, external_sensor_select = 1'b1;
    logic charge_irq_polarity = 1'b0, battery_good_polarity = 1'b0, pin_function_bit_hi = 1'b0;
    logic pin_function_bit_lo = 1'b1, removal_pulse_enable = 1'b0, init_ocv_pulse_enable = 1'b0;
    logic remaining_to_full_on_term = 1'b0, taper_window_end = 1'b0, temp_tick = 1'b0;
    logic battery_removed = 1'b0, init_done = 1'b0, ocv_busy = 1'b0, flash_update_req = 1'b0;
    logic flash_busy = 1'b0, restore_busy = 1'b0, query_req = 1'b0;
    logic [1:0] op_state = 2'h0;
    logic [7:0] soc_step = 8'h00, low_charge_set = 8'h0a, low_charge_clear = 8'h0f;
    logic [7:0] ot_chg_time = 8'h00, ot_dsg_time = 8'h00, relative_charge_pct = 8'h32;
    logic [15:0] flash_write_notice_delay = 16'h0000, shutdown_set_mv = 16'h0bb8;
    logic [15:0] shutdown_clear_mv = 16'h0c80, ot_chg = 16'h0fa0, ot_chg_recovery = 16'h0f00;
    logic [15:0] ot_dsg = 16'h0fa0, inhibit_low = 16'h0aaa, inhibit_high = 16'h0c6c;
    logic [15:0] temp_hys = 16'h0032, charging_voltage = 16'h1068, taper_voltage = 16'h0064;
    logic [15:0] cap_delta_uah = 16'h0000, voltage_mv = 16'h0ed8, thermistor_input = 16'h0ba4;
    logic [15:0] internal_temp = 16'h0bc2;
    logic signed [15:0] avg_current = 16'sh0000, chg_current_thr = 16'sh0064;
    logic signed [15:0] dsg_current_thr = 16'sh0064, taper_current = 16'sh0032;
    logic charge_irq, battery_good_n, temp_ready, charge_overheat_flag, discharge_overheat_flag;
    logic charging_flag, rm_load_fcc, flash_erase_start, temp_query, charger_off;
    logic [15:0] battery_temp, temp_seen;
    int n_errors = 0, n_compared = 0;
    gei_top #(.PULSE_CYCLES(P), .SECOND_CYCLES(50)) dut (.*);
    gei_host_model host (.*);
    initial
    begin
        forever #12.5 ref_clk = ~ref_clk;
    end
    // ==========================================
    // Shared tasks
    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic stop_test;
        if (n_errors == 0 && n_compared > 0)
        begin
            $display("verification passed");
        end
        else
        begin
            $display("verification failed");
        end
        $finish;
    endtask
    // ==========================================
    // Scenarios
    task automatic t_removal;
        battery_removed = 1'b1;
        cyc(1);
        battery_removed = 1'b0;
        cyc(3);
        chk("irq without enable", 16'h0001, 16'(charge_irq));
        removal_pulse_enable = 1'b1;
        battery_removed = 1'b1;
        cyc(1);
        battery_removed = 1'b0;
        cyc(2);
        chk("irq start", 16'h0000, 16'(charge_irq));
        cyc(P - 2);
        chk("irq held", 16'h0000, 16'(charge_irq));
        cyc(1);
        chk("irq end", 16'h0001, 16'(charge_irq));
    endtask
    task automatic query(input logic sel, input logic [15:0] exp);
        external_sensor_select = sel;
        query_req = 1'b1;
        cyc(1);
        query_req = 1'b0;
        cyc(4);
        chk("temperature", exp, temp_seen);
    endtask
    task automatic t_flash;
        logic seen = 1'b0;
        logic low = 1'b0;
        init_done = 1'b1;
        flash_update_req = 1'b1;
        cyc(1);
        flash_update_req = 1'b0;
        repeat (6)
        begin
            seen |= flash_erase_start;
            low |= ~charge_irq;
            cyc(1);
        end
        chk("erase start", 16'h0001, 16'(seen));
        chk("notice pulse", 16'h0000, 16'(low));
        flash_write_notice_delay = 16'h0001;
        flash_update_req = 1'b1;
        cyc(1);
        flash_update_req = 1'b0;
        cyc(2);
        chk("notice irq", 16'h0000, 16'(charge_irq));
        cyc(197);
        chk("early erase", 16'h0000, 16'(flash_erase_start));
        cyc(1);
        chk("delayed erase", 16'h0001, 16'(flash_erase_start));
    endtask
    task automatic temp_to(input logic [15:0] t, input logic exp);
        thermistor_input = t;
        temp_tick = 1'b1;
        cyc(1);
        temp_tick = 1'b0;
        cyc(5);
        chk("charger inhibit", 16'(exp), 16'(charger_off));
    endtask
    task automatic t_charge;
        op_state = 2'h1;
        avg_current = 16'sh00c8;
        ot_chg_time = 8'h01;
        remaining_to_full_on_term = 1'b1;
        temp_to(16'h0fa0, 1'b1);
        cyc(60);
        chk("charge overheat", 16'h0001, 16'(charge_overheat_flag));
        chk("charging set", 16'h0001, 16'(charging_flag));
        temp_to(16'h0f00, 1'b1);
        chk("overheat recovery", 16'h0000, 16'(charge_overheat_flag));
        avg_current = 16'sh0000;
        voltage_mv = 16'h1036;
        cap_delta_uah = 16'h012c;
        taper_window_end = 1'b1;
        cyc(1);
        taper_window_end = 1'b0;
        cyc(1);
        taper_window_end = 1'b1;
        cyc(1);
        taper_window_end = 1'b0;
        chk("load from full", 16'h0001, 16'(rm_load_fcc));
        chk("charging cleared", 16'h0000, 16'(charging_flag));
    endtask
    // ==========================================
    // Main sequence
    initial
    begin
        cyc(8);
        nrst = 1'b1;
        cyc(1);
        chk("idle irq", 16'h0001, 16'(charge_irq));
        chk("idle good", 16'h0000, 16'(battery_good_n));
        cyc(4);
        chk("no pulse after reset", 16'h0001, 16'(charge_irq));
        t_removal;
        query(1'b1, 16'h0ba4);
        query(1'b0, 16'h0bc2);
        t_flash;
        external_sensor_select = 1'b1;
        temp_to(16'h0ce4, 1'b1);
        temp_to(16'h0c4e, 1'b1);
        temp_to(16'h0c1c, 1'b0);
        t_charge;
        pin_function_bit_hi = 1'b1;
        pin_function_bit_lo = 1'b0;
        temp_to(16'h0b00, 1'b0);
        chk("no sample charging", 16'h0f00, battery_temp);
        soc_step = 8'h0a;
        op_state = 2'h2;
        cyc(2);
        chk("state change irq", 16'h0000, 16'(charge_irq));
        stop_test;
    end
    // The sequence needs under 400 cycles; twice that marks a hang.
    initial
    begin
        #20000;
        n_errors++;
        stop_test;
    end
endmodule // gauge_event_indicator_bench
